// ---- hw/dcm_pkg.sv ----
package dcm_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CAPACITY = 4'h0;
  localparam logic [3:0] ADDR_POLES = 4'h1;
  localparam logic [3:0] ADDR_METHOD = 4'h2;
  localparam logic [3:0] ADDR_TERM_BASE = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'hA;
  localparam logic [3:0] ADDR_GAIN = 4'hB;
  localparam int TERM_COUNT = 7;
  // Setting encodings; capacity is in units of 0.01 kW
  localparam logic [15:0] SET_NONE = 16'h270F;
  localparam logic [15:0] CAP_MIN = 16'h000A;
  localparam logic [15:0] CAP_MAX = 16'h05DC;
  localparam logic [15:0] POLES_MIN = 16'h0002;
  localparam logic [15:0] POLES_MAX = 16'h000A;
  localparam logic [15:0] METHOD_ADV = 16'h0014;
  localparam logic [15:0] METHOD_GP = 16'h001E;
  localparam logic [15:0] RST_CAPACITY = 16'h270F;
  localparam logic [15:0] RST_POLES = 16'h270F;
  localparam logic [15:0] RST_METHOD = 16'h0014;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam logic [7:0] FUNC_VF_SWITCH = 8'h12;
  localparam logic [7:0] RST_TERM_FUNC = 8'h00;
  // Status word field positions
  localparam int ST_METHOD_LSB = 0;
  localparam int ST_SECOND_BIT = 2;
  localparam int ST_PENDING_BIT = 3;
  // Active control method code
  typedef enum logic [1:0] {
    DCM_VF = 2'b00,
    DCM_ADV = 2'b01,
    DCM_GP = 2'b11
  } dcm_method_t;
endpackage

// ---- hw/dcm_selector.sv ----
// Behaviour
// - V/F mode keeps voltage proportional to frequency
// - Capacity accepts 0.1..15 kW or 9999
// - Pole count accepts 2..10 even or 9999
// - Code 20 advanced, 30 general-purpose vector
// - Any 9999 motor setting forces V/F
// - Reset: V/F, settings 9999, code 20
// - Switchover input replaces vector with V/F
// - Switchover only via terminal assigned 18
// - Method change deferred until drive stops
// - Forced V/F while running enables second set
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module dcm_selector
  import dcm_pkg::*;
#(
  parameter int TERMS = TERM_COUNT,
  parameter int FW = 16
) (
  input wire logic clk_i,                 // 40 MHz system clock
  input wire logic reset_i,               // Synchronous reset, active high
  input wire logic en_i,                  // Clock enable
  input wire logic [3:0] addr_i,          // Register address
  input wire logic [15:0] wdata_i,        // Register write data
  input wire logic wr_i,                  // Write strobe
  input wire logic rd_i,                  // Read strobe
  output logic [15:0] rdata_o,            // Read data, cycle after rd_i
  input wire logic [TERMS-1:0] term_i,    // Input terminal levels
  input wire logic running_i,             // Drive is running
  input wire logic [FW-1:0] freq_i,       // Output frequency command
  output logic [1:0] method_o,            // Active control method
  output logic second_func_o,             // Second function group active
  output logic [FW-1:0] vf_volt_o         // V/F voltage command
);

  ////////////////////////////////////////////////////////////////////////
  // Settings registers

  logic [15:0] cap_q;
  logic [15:0] poles_q;
  logic [15:0] code_q;
  logic [7:0] term_func_q [TERMS];
  logic [15:0] gain_q;

  function automatic logic cap_ok(input logic [15:0] v);
    cap_ok = (v == SET_NONE) || (v >= CAP_MIN && v <= CAP_MAX);
  endfunction

  function automatic logic poles_ok(input logic [15:0] v);
    poles_ok = (v == SET_NONE) ||
               (v >= POLES_MIN && v <= POLES_MAX && !v[0]);
  endfunction

  function automatic logic code_ok(input logic [15:0] v);
    code_ok = (v == METHOD_ADV) || (v == METHOD_GP);
  endfunction

  // Out-of-range writes are dropped, the old setting stays
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cap_q <= RST_CAPACITY;
      poles_q <= RST_POLES;
      code_q <= RST_METHOD;
      gain_q <= RST_GAIN;
    end else if (en_i && wr_i) begin
      if (addr_i == ADDR_CAPACITY && cap_ok(wdata_i)) begin
        cap_q <= wdata_i;
      end
      if (addr_i == ADDR_POLES && poles_ok(wdata_i)) begin
        poles_q <= wdata_i;
      end
      if (addr_i == ADDR_METHOD && code_ok(wdata_i)) begin
        code_q <= wdata_i;
      end
      if (addr_i == ADDR_GAIN) begin
        gain_q <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Terminal function assignment and switchover detection

  logic [TERMS-1:0] sw_hit;

  for (genvar t = 0; t < TERMS; t++) begin : g_term
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        term_func_q[t] <= RST_TERM_FUNC;
      end else if (en_i && wr_i &&
                   addr_i == ADDR_TERM_BASE + 4'(t)) begin
        term_func_q[t] <= wdata_i[7:0];
      end
    end
    assign sw_hit[t] = term_i[t] &&
                       (term_func_q[t] == FUNC_VF_SWITCH);
  end

  logic vf_switch;
  assign vf_switch = |sw_hit;

  ////////////////////////////////////////////////////////////////////////
  // Method selection

  dcm_method_t want;

  always_comb begin
    if (cap_q == SET_NONE || poles_q == SET_NONE) begin
      want = DCM_VF;
    end else if (vf_switch) begin
      want = DCM_VF;
    end else if (code_q == METHOD_GP) begin
      want = DCM_GP;
    end else begin
      want = DCM_ADV;
    end
  end

  dcm_method_t method_q;
  logic pending_q;

  // Active method follows the wanted one only while stopped
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      method_q <= DCM_VF;
      pending_q <= 1'b0;
    end else if (en_i) begin
      if (!running_i) begin
        method_q <= want;
        pending_q <= 1'b0;
      end else begin
        pending_q <= (want != method_q);
      end
    end
  end

  assign method_o = method_q;

  // Switchover raised while running in a vector method makes the second set valid
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      second_func_o <= 1'b0;
    end else if (en_i) begin
      if (running_i && vf_switch && method_q != DCM_VF) begin
        second_func_o <= 1'b1;
      end else if (!running_i) begin
        second_func_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Constant V/F: voltage = freq * gain / 256

  logic [FW+15:0] prod;
  assign prod = (FW+16)'(freq_i) * (FW+16)'(gain_q);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vf_volt_o <= '0;
    end else if (en_i) begin
      if (method_q == DCM_VF) begin
        vf_volt_o <= prod[FW+7:8];
      end else begin
        vf_volt_o <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [15:0] rmux;

  always_comb begin
    rmux = 16'h0000;
    if (addr_i == ADDR_CAPACITY) begin
      rmux = cap_q;
    end else if (addr_i == ADDR_POLES) begin
      rmux = poles_q;
    end else if (addr_i == ADDR_METHOD) begin
      rmux = code_q;
    end else if (addr_i == ADDR_STATUS) begin
      rmux[ST_METHOD_LSB +: 2] = method_q;
      rmux[ST_SECOND_BIT] = second_func_o;
      rmux[ST_PENDING_BIT] = pending_q;
    end else if (addr_i == ADDR_GAIN) begin
      rmux = gain_q;
    end else begin
      for (int k = 0; k < TERMS; k++) begin
        if (addr_i == ADDR_TERM_BASE + 4'(k)) begin
          rmux = {8'h00, term_func_q[k]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 16'h0000;
    end else if (en_i) begin
      rdata_o <= rd_i ? rmux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_method_holds_running: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (running_i && $past(running_i) && $past(en_i))
      |-> method_q == $past(method_q))
    else $error("active method changed while running");

  a_none_forces_vf: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i && (cap_q == SET_NONE || poles_q == SET_NONE))
      |=> method_q == DCM_VF)
    else $error("9999 setting did not force V/F");

  a_switch_forces_vf: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i && vf_switch) |=> method_q == DCM_VF)
    else $error("switchover did not force V/F");

  a_gp_select: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i && !vf_switch && cap_q != SET_NONE &&
     poles_q != SET_NONE && code_q == METHOD_GP) |=> method_q == DCM_GP)
    else $error("code 30 did not select general-purpose vector");

  a_cap_range: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cap_q == SET_NONE || (cap_q >= CAP_MIN && cap_q <= CAP_MAX))
    else $error("capacity outside accepted range");

  a_poles_range: assert property (
    @(posedge clk_i) disable iff (reset_i)
    poles_ok(poles_q))
    else $error("pole count outside accepted set");

  a_unassigned_ignored: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i && sw_hit == '0 && cap_q != SET_NONE &&
     poles_q != SET_NONE) |=> method_q != DCM_VF)
    else $error("switchover taken from unassigned terminal");

  a_second_on_force: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && running_i && vf_switch && method_q != DCM_VF)
      |=> second_func_o ##1 (!running_i || second_func_o))
    else $error("second function not raised on forced V/F");

  a_reset_state: assert property (
    @(posedge clk_i)
    $past(reset_i) |-> (method_q == DCM_VF && cap_q == RST_CAPACITY &&
                        code_q == RST_METHOD))
    else $error("reset state wrong");

  a_vf_ratio: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && method_q == DCM_VF) |=>
      vf_volt_o == FW'(((FW+16)'($past(freq_i)) * $past(gain_q)) >> 8))
    else $error("V/F voltage not proportional to frequency");

  a_volt_idle: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && method_q != DCM_VF) |=> vf_volt_o == '0)
    else $error("V/F voltage driven outside V/F mode");

  a_adv_select: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i && !vf_switch && cap_q != SET_NONE &&
     poles_q != SET_NONE && code_q == METHOD_ADV) |=> method_q == DCM_ADV)
    else $error("code 20 did not select advanced vector");

  a_pending_set: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && running_i && vf_switch && method_q != DCM_VF) |=> pending_q)
    else $error("deferred change not flagged while running");

  a_pending_clear: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i) |=> !pending_q)
    else $error("pending flag left set while stopped");

  a_second_clear: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (en_i && !running_i) |=> !second_func_o)
    else $error("second function left active while stopped");

  a_method_legal: assert property (
    @(posedge clk_i) disable iff (reset_i)
    method_q inside {DCM_VF, DCM_ADV, DCM_GP})
    else $error("illegal active method code");

  a_reset_outputs: assert property (
    @(posedge clk_i)
    $past(reset_i) |-> (!second_func_o && vf_volt_o == '0 &&
                        rdata_o == 16'h0000 && poles_q == RST_POLES))
    else $error("outputs not cleared by reset");

endmodule

// ---- testbench/dcm_term_model.sv ----
`timescale 1ns/100ps
module dcm_term_model #(
  parameter int TERMS = 7
) (
  input wire logic clk_i,          // System clock
  input wire logic level_i,        // Requested switchover level
  input wire logic [2:0] sel_i,    // Terminal that carries it
  output logic [TERMS-1:0] term_o  // Terminal levels
);
  // Only the selected terminal carries the level, the rest rest low
  initial term_o = '0;
  always @(posedge clk_i) begin
    term_o <= TERMS'(level_i) << sel_i;
  end
endmodule

// ---- testbench/drive_control_method_selector_tb.sv ----
`timescale 1ns/100ps
module drive_control_method_selector_tb;
  import dcm_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic running_i = 1'b0;
  logic [15:0] freq_i = 16'h0000;
  logic sw_lvl = 1'b0;
  logic [2:0] sw_sel = 3'h0;
  logic [6:0] term;
  logic [15:0] rdata_o;
  logic [15:0] vf_volt_o;
  logic [1:0] method_o;
  logic second_func_o;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  initial forever #12.5 clk_i = ~clk_i;
  dcm_selector dut_u (.clk_i(clk_i), .reset_i(reset_i), .en_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .term_i(term), .running_i(running_i),
    .freq_i(freq_i), .method_o(method_o),
    .second_func_o(second_func_o), .vf_volt_o(vf_volt_o));
  dcm_term_model term_u (.clk_i(clk_i), .level_i(sw_lvl),
    .sel_i(sw_sel), .term_o(term));
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic mchk(input logic [1:0] exp, input logic sec);
    chk({13'h0000, second_func_o, method_o}, {13'h0000, sec, exp}, "mode");
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp, "read");
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic sw(input logic lvl, input logic [2:0] sel);
    @(posedge clk_i);
    sw_lvl <= lvl;
    sw_sel <= sel;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    mchk(2'b00, 1'b0);
    rdchk(ADDR_CAPACITY, 16'h270F);
    rdchk(ADDR_POLES, 16'h270F);
    rdchk(ADDR_METHOD, 16'h0014);
  endtask
  task automatic t_ranges;
    logic [15:0] p [5] = '{16'h2, 16'h4, 16'h6, 16'h8, 16'hA};
    wr(ADDR_CAPACITY, 16'h0009);
    rdchk(ADDR_CAPACITY, 16'h270F);
    wr(ADDR_CAPACITY, 16'h05DD);
    rdchk(ADDR_CAPACITY, 16'h270F);
    wr(ADDR_CAPACITY, 16'h000A);
    rdchk(ADDR_CAPACITY, 16'h000A);
    settle();
    mchk(2'b00, 1'b0);
    wr(ADDR_POLES, 16'h0003);
    rdchk(ADDR_POLES, 16'h270F);
    foreach (p[i]) begin
      wr(ADDR_POLES, p[i]);
      rdchk(ADDR_POLES, p[i]);
    end
    settle();
    mchk(2'b01, 1'b0);
    wr(ADDR_METHOD, 16'h0019);
    rdchk(ADDR_METHOD, 16'h0014);
    wr(ADDR_METHOD, 16'h001E);
    wr(ADDR_CAPACITY, 16'h05DC);
    rdchk(ADDR_CAPACITY, 16'h05DC);
    settle();
    mchk(2'b11, 1'b0);
    wr(ADDR_POLES, 16'h270F);
    settle();
    mchk(2'b00, 1'b0);
    wr(ADDR_POLES, 16'h0004);
    settle();
    mchk(2'b11, 1'b0);
  endtask
  task automatic t_switch;
    wr(ADDR_TERM_BASE + 4'h2, 16'h0012);
    sw(1'b1, 3'h5);
    settle();
    mchk(2'b11, 1'b0);
    sw(1'b1, 3'h2);
    settle();
    mchk(2'b00, 1'b0);
    sw(1'b0, 3'h2);
    settle();
    mchk(2'b11, 1'b0);
  endtask
  task automatic t_run;
    @(posedge clk_i);
    running_i <= 1'b1;
    sw(1'b1, 3'h2);
    settle();
    mchk(2'b11, 1'b1);
    rdchk(ADDR_STATUS, 16'h000F);
    @(posedge clk_i);
    running_i <= 1'b0;
    settle();
    mchk(2'b00, 1'b0);
    sw(1'b0, 3'h2);
    settle();
    mchk(2'b11, 1'b0);
  endtask
  task automatic t_volt;
    @(posedge clk_i);
    freq_i <= 16'h1234;
    settle();
    chk(vf_volt_o, 16'h0000, "volt");
    wr(ADDR_CAPACITY, 16'h270F);
    settle();
    chk(vf_volt_o, 16'h1234, "volt");
    wr(ADDR_GAIN, 16'h0200);
    freq_i <= 16'h0300;
    settle();
    chk(vf_volt_o, 16'h0600, "volt");
    rdchk(4'hF, 16'h0000);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    t_reset();
    t_ranges();
    t_switch();
    t_run();
    t_volt();
    complete_run();
  end
endmodule
